// ---- inc/otp_writer_defines.vh ----
// constants shared by the fuse word programmer and its step timer
// assumes a 25 MHz system clock; times are derived into cycle counts
`ifndef OTP_WRITER_DEFINES_VH
`define OTP_WRITER_DEFINES_VH

// ****************************************
// clock and timing
// ****************************************
`define CLK_MHZ 25
`define BURN_TIME_US 20000
`define ZERO_TIME_NS 400
`define HOLD_TIME_US 5000
`define BANK_PULSE_NS 1000
`define TIMER_W 20

// ****************************************
// instruction fields
// ****************************************
`define XFER_NONE 2'h0
`define XFER_OUT_A 2'h1
`define XFER_OUT_B 2'h2
`define XFER_IN_A 2'h3
`define FUNC_NONE 2'h0
`define FUNC_START 2'h1
`define FUNC_CLEAR 2'h2
`define FUNC_PULSE 2'h3

// ****************************************
// word layout (host bit 0 is the msb, bit [15] here)
// ****************************************
`define ADDR_W 12
`define ADDR_MSB 11
`define BANK_MSB 11
`define BANK_LSB 9
`define BANK_N 8
`define DATA_W 16
`define DATA_MSB 15
`define MASK_BIT 0
`define BIT_CNT_LAST 4'hf
`define CODE_W 6

// ****************************************
// reset values
// ****************************************
`define DATA_RST 16'h0000
`define ADDR_RST 12'h000
`define CODE_RST 6'h00
`define BANK_RST 8'h00

`endif

// ---- rtl/otp_step_timer.v ----
// down counter that times each step of a programming cycle
// assumes load is a one-cycle pulse from the sequencer
`timescale 1ns/100ps
`include "otp_writer_defines.vh"

module otp_step_timer #(
	parameter W = `TIMER_W
) (
	input wire clk,
	input wire rst,
	input wire load,
	input wire [W-1:0] load_val,
	output wire expired
);
	reg [W-1:0] count_r;

	always @(posedge clk or posedge rst) begin
		if (rst) begin
			count_r <= {W{1'b0}};
		end else if (load) begin
			count_r <= load_val;
		end else if (count_r != {W{1'b0}}) begin
			count_r <= count_r - {{(W-1){1'b0}}, 1'b1};
		end
	end

	assign expired = (count_r == {W{1'b0}});
endmodule // otp_step_timer

// ---- rtl/otp_writer_unit.v ----
// Contract
// - hold 12-bit address and 16-bit data registers
// - readback samples live prom outputs, no latch
// - shift data left; ones burn, zeros skip
// - upper address picks one of eight banks
// - one bit 20 ms, zero bit 400 ns
// - address keeps selecting word 5 ms after
// - set done, keep location readable 5 ms
// - start sets busy, clears done, launches cycle
// - clear forces busy low, and done low unless the last bit ends in that cycle
// - pulse clears done only; done stays set if the last bit ends in that cycle
// - output b loads address from bits 4-15
// - output a loads all sixteen data bits
// - input a returns live word at current prom address
// - transfer first, then device-flag function
// - answer only matching jumpered device code
// - bus reset clears flags, reloads code, polarity
// - mask bit 15 suppresses interrupt request
//
// fuse word programmer: i/o bus instruction decode, busy/done flags,
// bit sequencer driving the bank and bit programming relays
// assumes one IO_STROBE per instruction, all inputs synchronous to SYS_CLK
`timescale 1ns/100ps
`include "otp_writer_defines.vh"

module otp_writer_unit #(
	parameter BURN_CYC = `BURN_TIME_US * `CLK_MHZ,
	parameter HOLD_CYC = `HOLD_TIME_US * `CLK_MHZ
) (
	input wire SYS_CLK,
	input wire RESET,
	input wire IO_STROBE,
	input wire [`CODE_W-1:0] IO_DEVICE,
	input wire [1:0] IO_XFER,
	input wire [1:0] IO_FUNC,
	input wire [`DATA_W-1:0] IO_DATA_IN,
	input wire BUS_WIDE_RESET,
	input wire INTERRUPT_MASK_OUT,
	input wire [`CODE_W-1:0] JUMPER_CODE,
	input wire JUMPER_POLARITY,
	input wire [`DATA_W-1:0] PROM_DATA,
	output reg [`DATA_W-1:0] IO_DATA_OUT,
	output reg IO_DATA_VALID,
	output reg BUSY,
	output reg DONE,
	output reg INT_REQ,
	output reg [`ADDR_W-1:0] PROM_ADDR,
	output reg [`BANK_N-1:0] BANK_VCC,
	output reg BANK_ENABLE_PULSE,
	output reg [`DATA_W-1:0] BIT_VPP
);

	// ****************************************
	// timing counts
	// ****************************************
	localparam ZERO_CYC = (`ZERO_TIME_NS * `CLK_MHZ) / 1000;
	localparam BANK_CYC = (`BANK_PULSE_NS * `CLK_MHZ) / 1000;

	// ****************************************
	// sequencer states, one-hot
	// ****************************************
	localparam S_IDLE = 6'b000001;
	localparam S_BANK = 6'b000010;
	localparam S_SHIFT = 6'b000100;
	localparam S_BURN = 6'b001000;
	localparam S_SKIP = 6'b010000;
	localparam S_HOLD = 6'b100000;

	// ****************************************
	// helpers
	// ****************************************
	// negative-logic jumper inverts the data path both ways
	function [`DATA_W-1:0] pol;
		input [`DATA_W-1:0] v;
		input p;
		begin
			pol = p ? v : ~v;
		end
	endfunction

	// minus one so the step length counts the entry cycle
	function [`TIMER_W-1:0] steps;
		input integer n;
		begin
			steps = (n > 1) ? n[`TIMER_W-1:0] - {{(`TIMER_W-1){1'b0}}, 1'b1}
				: {`TIMER_W{1'b0}};
		end
	endfunction

	// one-hot vcc relay select from the bank bits of an address
	function [`BANK_N-1:0] bank_sel;
		input [`ADDR_W-1:0] a;
		begin
			bank_sel = {{(`BANK_N-1){1'b0}}, 1'b1} << a[`BANK_MSB:`BANK_LSB];
		end
	endfunction

	// ****************************************
	// state
	// ****************************************
	reg [5:0] state_r;
	reg [5:0] state_nxt;
	reg [`DATA_W-1:0] data_r;
	reg [`DATA_W-1:0] data_nxt;
	reg [`ADDR_W-1:0] addr_r;
	reg [`ADDR_W-1:0] addr_nxt;
	reg [`DATA_W-1:0] shift_r;
	reg [`DATA_W-1:0] shift_nxt;
	reg [3:0] bit_r;
	reg [3:0] bit_nxt;
	reg busy_nxt;
	reg done_nxt;
	reg mask_r;
	reg mask_nxt;
	reg [`CODE_W-1:0] code_r;
	reg polarity_r;
	reg init_pend_r;
	reg tmr_load;
	reg [`TIMER_W-1:0] tmr_val;
	wire tmr_done;
	wire hit;
	wire [`DATA_W-1:0] host_word;
	wire start_req;
	wire last_bit_end;

	assign hit = IO_STROBE && (IO_DEVICE == code_r);
	assign host_word = pol(IO_DATA_IN, polarity_r);
	assign start_req = hit && (IO_FUNC == `FUNC_START) && !BUSY;
	// final bit step expiring: the one cycle that ends a programming pass
	assign last_bit_end = (state_r == S_BURN || state_r == S_SKIP) && tmr_done
		&& (bit_r == `BIT_CNT_LAST);

	otp_step_timer #(
		.W(`TIMER_W)
	) u_timer (
		.clk(SYS_CLK),
		.rst(RESET),
		.load(tmr_load),
		.load_val(tmr_val),
		.expired(tmr_done)
	);

	// ****************************************
	// jumper capture
	// ****************************************
	// straps are sampled after reset release, never under the reset itself
	always @(posedge SYS_CLK or posedge RESET) begin
		if (RESET) begin
			init_pend_r <= 1'b1;
			code_r <= `CODE_RST;
			polarity_r <= 1'b1;
		end else begin
			init_pend_r <= 1'b0;
			if (init_pend_r || BUS_WIDE_RESET) begin
				code_r <= JUMPER_CODE;
				polarity_r <= JUMPER_POLARITY;
			end
		end
	end

	// ****************************************
	// instruction decode and sequencer
	// ****************************************
	always @* begin
		data_nxt = data_r;
		addr_nxt = addr_r;
		shift_nxt = shift_r;
		bit_nxt = bit_r;
		busy_nxt = BUSY;
		done_nxt = DONE;
		mask_nxt = mask_r;
		state_nxt = state_r;
		tmr_load = 1'b0;
		tmr_val = {`TIMER_W{1'b0}};

		if (INTERRUPT_MASK_OUT) begin
			mask_nxt = host_word[`MASK_BIT];
		end

		// transfer part of the instruction
		if (hit && IO_XFER == `XFER_OUT_A) begin
			data_nxt = host_word;
		end
		if (hit && IO_XFER == `XFER_OUT_B) begin
			addr_nxt = host_word[`ADDR_MSB:0];
		end

		// flag part follows, so a start sees the word just loaded
		if (hit) begin
			case (IO_FUNC)
			`FUNC_CLEAR: begin
				busy_nxt = 1'b0;
				done_nxt = 1'b0;
			end
			`FUNC_PULSE: begin
				done_nxt = 1'b0;
			end
			default: begin
			end
			endcase
		end

		case (state_r)
		S_IDLE: begin
		end
		S_BANK: begin
			if (tmr_done) begin
				state_nxt = S_SHIFT;
			end
		end
		S_SHIFT: begin
			// msb is the bit shifted out
			shift_nxt = {shift_r[`DATA_MSB-1:0], 1'b0};
			tmr_load = 1'b1;
			if (shift_r[`DATA_MSB]) begin
				tmr_val = steps(BURN_CYC);
				state_nxt = S_BURN;
			end else begin
				tmr_val = steps(ZERO_CYC);
				state_nxt = S_SKIP;
			end
		end
		S_BURN, S_SKIP: begin
			if (tmr_done) begin
				if (bit_r == `BIT_CNT_LAST) begin
					busy_nxt = 1'b0;
					done_nxt = 1'b1;
					tmr_load = 1'b1;
					tmr_val = steps(HOLD_CYC);
					state_nxt = S_HOLD;
				end else begin
					bit_nxt = bit_r + 4'h1;
					state_nxt = S_SHIFT;
				end
			end
		end
		S_HOLD: begin
			if (tmr_done) begin
				state_nxt = S_IDLE;
			end
		end
		default: begin
			state_nxt = S_IDLE;
		end
		endcase

		// a clear aborts the cycle in flight
		if (hit && IO_FUNC == `FUNC_CLEAR) begin
			state_nxt = S_IDLE;
		end

		// taken in the hold window too: busy is already low there
		if (start_req) begin
			busy_nxt = 1'b1;
			done_nxt = 1'b0;
			shift_nxt = data_nxt;
			bit_nxt = 4'h0;
			tmr_load = 1'b1;
			tmr_val = steps(BANK_CYC);
			state_nxt = S_BANK;
		end

		// completion in the same cycle as a host clear still reports done
		if (last_bit_end && !start_req) begin
			done_nxt = 1'b1;
		end

		if (BUS_WIDE_RESET) begin
			busy_nxt = 1'b0;
			done_nxt = 1'b0;
			state_nxt = S_IDLE;
		end
	end

	// ****************************************
	// registers and relay drive
	// ****************************************
	always @(posedge SYS_CLK or posedge RESET) begin
		if (RESET) begin
			state_r <= S_IDLE;
			data_r <= `DATA_RST;
			addr_r <= `ADDR_RST;
			shift_r <= `DATA_RST;
			bit_r <= 4'h0;
			mask_r <= 1'b0;
			BUSY <= 1'b0;
			DONE <= 1'b0;
			INT_REQ <= 1'b0;
			IO_DATA_OUT <= `DATA_RST;
			IO_DATA_VALID <= 1'b0;
			PROM_ADDR <= `ADDR_RST;
			BANK_VCC <= `BANK_RST;
			BANK_ENABLE_PULSE <= 1'b0;
			BIT_VPP <= `DATA_RST;
		end else begin
			state_r <= state_nxt;
			data_r <= data_nxt;
			addr_r <= addr_nxt;
			shift_r <= shift_nxt;
			bit_r <= bit_nxt;
			mask_r <= mask_nxt;
			BUSY <= busy_nxt;
			DONE <= done_nxt;
			INT_REQ <= done_nxt && !mask_nxt;

			// one-cycle sample of the live prom outputs, nothing held
			IO_DATA_VALID <= hit && (IO_XFER == `XFER_IN_A);
			if (hit && IO_XFER == `XFER_IN_A) begin
				IO_DATA_OUT <= pol(PROM_DATA, polarity_r);
			end

			// address is frozen while a cycle or its hold window runs
			// a start inside a hold window must take the new address as well
			if (state_nxt == S_IDLE || start_req) begin
				PROM_ADDR <= addr_nxt;
			end

			// otherwise a restart would power the previous word's bank
			if (state_nxt == S_IDLE) begin
				BANK_VCC <= `BANK_RST;
			end else if (start_req) begin
				BANK_VCC <= bank_sel(addr_nxt);
			end else begin
				BANK_VCC <= bank_sel(PROM_ADDR);
			end
			BANK_ENABLE_PULSE <= (state_nxt == S_BANK);

			// one relay per bit, only while that bit burns
			BIT_VPP <= `DATA_RST;
			if (state_nxt == S_BURN) begin
				BIT_VPP[`DATA_MSB - bit_nxt] <= 1'b1;
			end
		end
	end

endmodule // otp_writer_unit

// ---- bench/otp_writer_unit_chk.sv ----
// port checker for the fuse word programmer
// assumes a fixed code jumper; polarity is mirrored from the bus resets
`timescale 1ns/100ps
module otp_writer_unit_chk #(
	parameter BURN_CYC = 20,
	parameter HOLD_CYC = 16
) (
	input wire SYS_CLK,
	input wire RESET,
	input wire IO_STROBE,
	input wire [5:0] IO_DEVICE,
	input wire [1:0] IO_XFER,
	input wire [1:0] IO_FUNC,
	input wire [15:0] IO_DATA_IN,
	input wire BUS_WIDE_RESET,
	input wire INTERRUPT_MASK_OUT,
	input wire [5:0] JUMPER_CODE,
	input wire JUMPER_POLARITY,
	input wire [15:0] PROM_DATA,
	input wire [15:0] IO_DATA_OUT,
	input wire IO_DATA_VALID,
	input wire BUSY,
	input wire DONE,
	input wire INT_REQ,
	input wire [11:0] PROM_ADDR,
	input wire [7:0] BANK_VCC,
	input wire [15:0] BIT_VPP
);
	reg mask_r;
	reg pol_r;
	reg init_r;
	integer burn_cnt;
	integer hold_cnt;
	wire hit = IO_STROBE && IO_DEVICE == JUMPER_CODE;
	wire brst = BUS_WIDE_RESET;
	// mirrors of mask and captured polarity; bus reset leaves the mask alone
	always @(posedge SYS_CLK or posedge RESET) begin
		if (RESET) begin
			mask_r <= 1'b0;
			pol_r <= 1'b1;
			init_r <= 1'b1;
		end else begin
			init_r <= 1'b0;
			if (INTERRUPT_MASK_OUT)
				mask_r <= pol_r ? IO_DATA_IN[0] : ~IO_DATA_IN[0];
			if (init_r || brst)
				pol_r <= JUMPER_POLARITY;
		end
	end
	// run lengths of relay on-times, too long for a repetition
	always @(posedge SYS_CLK or posedge RESET) begin
		if (RESET) begin
			burn_cnt <= 0;
			hold_cnt <= 0;
		end else begin
			burn_cnt <= (|BIT_VPP) ? burn_cnt + 1 : 0;
			hold_cnt <= (DONE && !BUSY && |BANK_VCC) ? hold_cnt + 1 : 0;
		end
	end
	default clocking @(posedge SYS_CLK); endclocking
	default disable iff (RESET);
	a_start_sets_busy: assert property (hit && IO_FUNC == 2'h1 && !BUSY && !brst
		|=> BUSY && !DONE) else $error("start did not raise busy");
	a_clear_both: assert property (hit && IO_FUNC == 2'h2 |=> !BUSY && !DONE)
		else $error("clear left a flag set");
	a_pulse_done_only: assert property (hit && IO_FUNC == 2'h3 && !brst
		|=> !DONE && BUSY == $past(BUSY)) else $error("pulse disturbed busy");
	a_bus_reset_flags: assert property (brst |=> !BUSY && !DONE)
		else $error("bus reset left a flag set");
	a_done_ends_busy: assert property ($rose(DONE) |-> $fell(BUSY))
		else $error("done rose without busy falling");
	a_mask_gates_req: assert property ($rose(DONE) |-> INT_REQ == !mask_r)
		else $error("interrupt request ignores mask");
	a_readback_live: assert property (hit && IO_XFER == 2'h3
		|=> IO_DATA_VALID
		&& IO_DATA_OUT == ($past(pol_r) ? $past(PROM_DATA) : ~$past(PROM_DATA)))
		else $error("readback mismatch");
	a_foreign_code: assert property (IO_STROBE && IO_DEVICE != JUMPER_CODE && !BUSY && !brst
		|=> !BUSY && $stable(DONE)) else $error("foreign code was answered");
	a_bank_select: assert property (|BANK_VCC |-> BANK_VCC == 8'h01 << PROM_ADDR[11:9])
		else $error("wrong bank powered");
	a_burn_in_bank: assert property (|BIT_VPP |-> $onehot(BIT_VPP) && |BANK_VCC && BUSY)
		else $error("bit relay outside a burn");
	a_hold_select: assert property ($fell(BUSY) && DONE |-> (|BANK_VCC)[*8])
		else $error("word dropped too early");
	a_burn_length: assert property (burn_cnt != 0 && BUSY
		|-> (|BIT_VPP) == (burn_cnt < BURN_CYC)) else $error("burn step length wrong");
	a_hold_length: assert property (hold_cnt != 0 && DONE && !BUSY
		|-> (|BANK_VCC) == (hold_cnt < HOLD_CYC)) else $error("hold window length wrong");
endmodule // otp_writer_unit_chk
bind otp_writer_unit otp_writer_unit_chk #(.BURN_CYC(BURN_CYC), .HOLD_CYC(HOLD_CYC)) i_chk (.*);

// ---- bench/prom_board_model.sv ----
// behavioural fuse prom board: one bits burn while bank and bit are powered
// assumes the board is blank (all zero) at start
`timescale 1ns/100ps
module prom_board_model (
	input wire clk,
	input wire [11:0] addr,
	input wire [7:0] vcc,
	input wire [15:0] vpp,
	output wire [15:0] data
);
	reg [15:0] mem [0:4095];
	reg [15:0] last_r = 16'h0000;
	integer i;
	initial begin
		for (i = 0; i < 4096; i = i + 1)
			mem[i] = 16'h0000;
	end
	always @(posedge clk) begin
		if (|vcc) begin
			mem[addr] <= mem[addr] | vpp;
			last_r <= mem[addr];
		end
	end
	// unpowered board floats: show the inverse so stale data never matches
	assign data = |vcc ? mem[addr] : ~last_r;
endmodule // prom_board_model

// ---- bench/otp_writer_unit_tb.sv ----
// testbench for the fuse word programmer with a prom board model
// assumes short burn and hold counts; polarity jumper flipped near the end
`timescale 1ns/100ps
module otp_writer_unit_tb;
	localparam [5:0] CODE = 6'h2a; // arbitrary strap code
	reg clk = 1'b0;
	reg rst = 1'b1;
	reg stb = 1'b0, bwr = 1'b0, msk = 1'b0;
	reg pol = 1'b1;
	reg [1:0] xfer = 2'h0, func = 2'h0;
	reg [5:0] dev = 6'h00;
	reg [15:0] din = 16'h0000;
	wire [15:0] prom, dout, vpp;
	wire [11:0] addr;
	wire [7:0] vcc;
	wire valid, busy, done, irq, en;
	integer num_errors = 0, num_checks = 0, cyc = 0, n1, n2;
	always #20 clk = ~clk;
	otp_writer_unit #(.BURN_CYC(20), .HOLD_CYC(16)) i_dut (
		.SYS_CLK(clk), .RESET(rst), .IO_STROBE(stb), .IO_DEVICE(dev),
		.IO_XFER(xfer), .IO_FUNC(func), .IO_DATA_IN(din), .BUS_WIDE_RESET(bwr),
		.INTERRUPT_MASK_OUT(msk), .JUMPER_CODE(CODE), .JUMPER_POLARITY(pol),
		.PROM_DATA(prom), .IO_DATA_OUT(dout), .IO_DATA_VALID(valid), .BUSY(busy),
		.DONE(done), .INT_REQ(irq), .PROM_ADDR(addr), .BANK_VCC(vcc),
		.BANK_ENABLE_PULSE(en), .BIT_VPP(vpp));
	prom_board_model i_prom (.clk(clk), .addr(addr), .vcc(vcc), .vpp(vpp), .data(prom));
	task chk(input [15:0] s, input [15:0] e);
		begin
			num_checks = num_checks + 1;
			if (s !== e) begin
				num_errors = num_errors + 1;
				$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
			end
		end
	endtask
	// one instruction; returns just after the edge that takes it
	task io(input [1:0] x, input [1:0] f, input [15:0] d, input [5:0] dv);
		begin
			@(posedge clk);
			stb <= 1'b1;
			xfer <= x;
			func <= f;
			din <= d;
			dev <= dv;
			@(posedge clk);
			stb <= 1'b0;
			#1;
		end
	endtask
	task mask(input b);
		begin
			@(posedge clk);
			msk <= 1'b1;
			din <= {15'h0000, b};
			@(posedge clk);
			msk <= 1'b0;
		end
	endtask
	task wt(output integer n);
		begin
			n = 0;
			while (done !== 1'b1 && n < 2000) begin
				@(posedge clk);
				#1;
				n = n + 1;
			end
			// a cycle that never ends is a failure in itself
			if (done !== 1'b1)
				num_errors = num_errors + 1;
		end
	endtask
	task wrap_up;
		begin
			$display("checks=%0d errors=%0d", num_checks, num_errors);
			if (num_errors == 0 && num_checks > 0)
				$display("STATUS OK");
			else
				$display("STATUS NOT OK");
			$finish;
		end
	endtask
	// bound well above the fewer than two thousand cycles the sequence needs
	always @(posedge clk) begin
		cyc = cyc + 1;
		if (cyc == 20000) begin
			num_errors = num_errors + 1;
			wrap_up;
		end
	end
	initial begin
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		#1;
		chk({busy, done, irq, vcc}, 16'h0000);
		$display("test reset done");
		io(2'h1, 2'h0, 16'h8001, CODE);
		io(2'h2, 2'h1, 16'hf40a, CODE);
		chk({busy, done}, 16'h0002);
		chk(en, 1'b1);
		repeat (24) @(posedge clk);
		#1;
		chk(en, 1'b1);
		@(posedge clk);
		#1;
		chk(en, 1'b0);
		wt(n1);
		chk({busy, done, irq}, 16'h0003);
		chk(addr, 16'h040a);
		chk(vcc, 16'h0004);
		io(2'h3, 2'h0, 16'h0000, CODE);
		chk(valid, 1'b1);
		chk(dout, 16'h8001);
		io(2'h0, 2'h3, 16'h0000, CODE);
		chk(done, 1'b0);
		$display("test program done");
		io(2'h2, 2'h0, 16'h040a, CODE);
		io(2'h1, 2'h1, 16'h0000, CODE);
		wt(n1);
		// bank step 25, then sixteen zero bits of 1 shift + 10 cycles
		chk(n1, 16'h00c9);
		io(2'h3, 2'h0, 16'h0000, CODE);
		chk(dout, 16'h8001);
		io(2'h2, 2'h0, 16'h040a, CODE);
		io(2'h1, 2'h1, 16'h0000, CODE);
		repeat (5) @(posedge clk);
		io(2'h0, 2'h1, 16'h0000, CODE);
		wt(n2);
		chk(n2 + 7, n1);
		$display("test verify done");
		mask(1'b1);
		io(2'h1, 2'h0, 16'h0100, CODE);
		io(2'h2, 2'h1, 16'h0bff, CODE);
		wt(n1);
		chk({done, irq}, 16'h0002);
		chk(vcc, 16'h0020);
		io(2'h3, 2'h0, 16'h0000, CODE);
		chk(dout, 16'h0100);
		io(2'h2, 2'h1, 16'h0000, CODE ^ 6'h01);
		chk({busy, done}, 16'h0001);
		repeat (20) @(posedge clk);
		bwr <= 1'b1;
		@(posedge clk);
		bwr <= 1'b0;
		#1;
		chk({busy, done}, 16'h0000);
		mask(1'b0);
		$display("test mask done");
		io(2'h1, 2'h0, 16'h00ff, CODE);
		io(2'h2, 2'h1, 16'h0123, CODE);
		io(2'h0, 2'h3, 16'h0000, CODE);
		chk(busy, 1'b1);
		repeat (40) @(posedge clk);
		io(2'h0, 2'h2, 16'h0000, CODE);
		chk({busy, done}, 16'h0000);
		repeat (400) @(posedge clk);
		#1;
		chk(done, 1'b0);
		$display("test abort done");
		@(posedge clk);
		pol <= 1'b0;
		bwr <= 1'b1;
		@(posedge clk);
		bwr <= 1'b0;
		// negative logic: host words below are the inverses of 0bff and 0000
		io(2'h2, 2'h0, 16'hf400, CODE);
		io(2'h1, 2'h1, 16'hffff, CODE);
		wt(n1);
		chk({busy, done, irq}, 16'h0003);
		chk(vcc, 16'h0020);
		io(2'h3, 2'h0, 16'h0000, CODE);
		chk(dout, 16'hfeff);
		$display("test polarity done");
		wrap_up;
	end
endmodule // otp_writer_unit_tb
